/* src/cllc_pkg.sv */
// Shared constants, register layout and carrier types of the cache line lock control block.
package cllc_pkg;

	// ****************************************
	// Register offsets and bus width
	// ****************************************
	localparam int APB_AW = 8;
	localparam logic [7:0] ADDR_L1D_CS = 8'h00;
	localparam logic [7:0] ADDR_L1I_CS = 8'h04;
	localparam logic [7:0] ADDR_L2_CS = 8'h08;
	localparam logic [7:0] ADDR_PROTECT = 8'h0c;
	localparam logic [7:0] ADDR_MSTATE = 8'h10;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int BIT_EN = 0;
	localparam int BIT_FINV = 1;
	localparam int BIT_LFC = 2;
	localparam int BIT_UL = 3;
	localparam int BIT_LO = 4;
	localparam int BIT_L2_OA = 5;
	localparam int BIT_L2_DO = 6;
	localparam int BIT_L2_IO = 7;
	localparam int BIT_PROTECT = 0;
	localparam int BIT_USER = 0;
	localparam int BIT_GUEST = 1;
	localparam int BIT_ULE = 2;
	localparam int ATTR_CI_BIT = 3;
	localparam int LINE_OFS_W = 6;

	// ****************************************
	// Target caches and cache indices
	// ****************************************
	localparam logic [1:0] TGT_L1 = 2'h0;
	localparam logic [1:0] TGT_L2 = 2'h2;
	localparam logic [1:0] CI_L1D = 2'h0;
	localparam logic [1:0] CI_L1I = 2'h1;
	localparam logic [1:0] CI_L2 = 2'h2;
	localparam int NCACHE = 3;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic RST_EN = 1'b0;
	localparam logic RST_FLAG = 1'b0;
	localparam logic [3:0] RST_RR = 4'h0;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		OP_DATA_LOCK_CLEAR = 3'h0,
		OP_DATA_TOUCH_LOCK = 3'h1,
		OP_DATA_STORE_LOCK = 3'h2,
		OP_INSTR_LOCK_CLEAR = 3'h3,
		OP_INSTR_TOUCH_LOCK = 3'h4
	} cllc_kind_t;

	typedef enum logic [1:0] {
		EXC_NONE = 2'h0,
		EXC_PRIVILEGED = 2'h1,
		EXC_HYP_PRIVILEGE = 2'h2
	} cllc_exc_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EXEC = 3'b010,
		ST_FILL = 3'b100
	} cllc_st_t;

	typedef struct packed {
		cllc_kind_t kind;
		logic [1:0] target_cache_select;
		logic [31:0] addr;
		logic [4:0] page_attribute_bits;
	} cllc_op_t;

	typedef struct packed {
		logic d_en;
		logic data_unable_to_lock_flag;
		logic data_overlock_flag;
		logic i_en;
		logic instr_unable_to_lock_flag;
		logic instr_overlock_flag;
		logic l2_en;
		logic l2_overlock_flag;
		logic l2_overlock_allocate;
		logic l2_data_only;
		logic l2_instr_only;
		logic lock_privilege_protect;
		logic user_mode_bit;
		logic guest_state_bit;
		logic user_lock_enable;
	} cllc_regs_t;

	typedef struct packed {
		cllc_st_t st;
		cllc_op_t op;
		logic [1:0] ci;
		logic [3:0] victim;
		logic [3:0] rr;
		cllc_regs_t regs;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic done;
		cllc_exc_t exc;
		logic locked;
		logic modified;
		logic fill_req;
	} cllc_state_t;

endpackage

/* src/cllc_top.sv */
// Cache line lock control: lock operations, lock flags, flash clears and the APB register file.
// How it works
// - With protect set, guest supervisor lock operations take a hypervisor privilege exception.
// - User mode lock permission depends only on user lock enable, not on protect.
// - Lock clear removes the lock of the addressed line in the target cache.
// - Touch and lock set fetches the line if absent and marks it locked.
// - Touch for store and lock set also marks the line modified.
// - Unable to lock leaves the line alone and sets the data or instruction flag.
// - Unable to lock when target cache disabled or page is caching inhibited.
// - Unable to lock on L2 when its data-only or instruction-only bit forbids it.
// - A fill error from the interconnect or L2 makes the operation unable to lock.
// - Overlock when every way of the target set is already locked.
// - L1 overlock sets data or instruction overlock flag, loads and locks nothing.
// - L2 overlock sets its flag; allocate bit decides replacing the normal victim.
// - Writing L1 lock flash clear bits clears every lock bit of that cache.
// - Writing the L2 lock flash clear bit clears every L2 lock bit.
// - Flash invalidate of an L1 cache also drops all its locks.
// - Touch and lock set operations always execute, never dropped as hints.
// - Lock clear does nothing when the target cache is disabled.
// - User state without user lock enable raises privileged exception; guest supervisor with protect raises hypervisor privilege exception.
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module cllc_top #(
	parameter int SETS = 16,
	parameter int WAYS = 4
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [cllc_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Lock operations from the pipeline
	input wire logic op_valid,
	input wire cllc_pkg::cllc_op_t op,
	output logic op_ready,
	output logic op_done,
	output cllc_pkg::cllc_exc_t op_exc,
	output logic op_locked,
	output logic op_modified,
	// Line fill port
	output logic fill_req,
	output logic [31:0] fill_addr,
	output logic [1:0] fill_target,
	input wire logic fill_ack,
	input wire logic fill_err
);

	localparam int SET_W = $clog2(SETS);
	localparam int WAY_W = $clog2(WAYS);
	localparam int TAG_W = 32 - cllc_pkg::LINE_OFS_W - SET_W;

	cllc_pkg::cllc_state_t r;
	cllc_pkg::cllc_state_t n;

	logic valid_mem [cllc_pkg::NCACHE][SETS][WAYS];
	logic lock_mem [cllc_pkg::NCACHE][SETS][WAYS];
	logic mod_mem [cllc_pkg::NCACHE][SETS][WAYS];
	logic [TAG_W-1:0] tag_mem [cllc_pkg::NCACHE][SETS][WAYS];

	logic [SET_W-1:0] lk_set;
	logic [TAG_W-1:0] lk_tag;
	logic hit;
	logic [WAY_W-1:0] hit_way;
	logic all_locked;
	logic [WAY_W-1:0] free_way;
	logic enabled;
	logic is_instr;
	logic is_clear;
	logic unable;
	cllc_pkg::cllc_exc_t exc;
	logic apb_wr;
	logic wr_en;
	logic [WAY_W-1:0] wr_way;
	logic wr_lock;
	logic wr_mod;
	logic wr_fill;
	logic [cllc_pkg::NCACHE-1:0] flash_lock;
	logic [cllc_pkg::NCACHE-1:0] flash_inv;

	// ****************************************
	// Register decode
	// ****************************************
	function automatic logic addr_ok(logic [cllc_pkg::APB_AW-1:0] a);
		addr_ok = (a == cllc_pkg::ADDR_L1D_CS) || (a == cllc_pkg::ADDR_L1I_CS) ||
			(a == cllc_pkg::ADDR_L2_CS) || (a == cllc_pkg::ADDR_PROTECT) ||
			(a == cllc_pkg::ADDR_MSTATE);
	endfunction

	function automatic logic [31:0] reg_read(cllc_pkg::cllc_regs_t g,
		logic [cllc_pkg::APB_AW-1:0] a);
		reg_read = 32'h0000_0000;
		case (a)
			cllc_pkg::ADDR_L1D_CS:
			begin
				reg_read[cllc_pkg::BIT_EN] = g.d_en;
				reg_read[cllc_pkg::BIT_UL] = g.data_unable_to_lock_flag;
				reg_read[cllc_pkg::BIT_LO] = g.data_overlock_flag;
			end
			cllc_pkg::ADDR_L1I_CS:
			begin
				reg_read[cllc_pkg::BIT_EN] = g.i_en;
				reg_read[cllc_pkg::BIT_UL] = g.instr_unable_to_lock_flag;
				reg_read[cllc_pkg::BIT_LO] = g.instr_overlock_flag;
			end
			cllc_pkg::ADDR_L2_CS:
			begin
				reg_read[cllc_pkg::BIT_EN] = g.l2_en;
				reg_read[cllc_pkg::BIT_LO] = g.l2_overlock_flag;
				reg_read[cllc_pkg::BIT_L2_OA] = g.l2_overlock_allocate;
				reg_read[cllc_pkg::BIT_L2_DO] = g.l2_data_only;
				reg_read[cllc_pkg::BIT_L2_IO] = g.l2_instr_only;
			end
			cllc_pkg::ADDR_PROTECT:
				reg_read[cllc_pkg::BIT_PROTECT] = g.lock_privilege_protect;
			cllc_pkg::ADDR_MSTATE:
			begin
				reg_read[cllc_pkg::BIT_USER] = g.user_mode_bit;
				reg_read[cllc_pkg::BIT_GUEST] = g.guest_state_bit;
				reg_read[cllc_pkg::BIT_ULE] = g.user_lock_enable;
			end
			default:
				reg_read = 32'h0000_0000;
		endcase
	endfunction

	// ****************************************
	// Set lookup
	// ****************************************
	assign lk_set = r.op.addr[cllc_pkg::LINE_OFS_W +: SET_W];
	assign lk_tag = r.op.addr[31 -: TAG_W];

	always_comb
	begin
		hit = 1'b0;
		hit_way = '0;
		all_locked = 1'b1;
		free_way = '0;
		for (int w = WAYS - 1; w >= 0; w--)
		begin
			if (valid_mem[r.ci][lk_set][w] && tag_mem[r.ci][lk_set][w] == lk_tag)
			begin
				hit = 1'b1;
				hit_way = WAY_W'(w);
			end
			if (!lock_mem[r.ci][lk_set][w])
			begin
				all_locked = 1'b0;
				free_way = WAY_W'(w);
			end
		end
	end

	// ****************************************
	// Operation decode
	// ****************************************
	always_comb
	begin
		is_instr = (r.op.kind == cllc_pkg::OP_INSTR_LOCK_CLEAR) ||
			(r.op.kind == cllc_pkg::OP_INSTR_TOUCH_LOCK);
		is_clear = (r.op.kind == cllc_pkg::OP_DATA_LOCK_CLEAR) ||
			(r.op.kind == cllc_pkg::OP_INSTR_LOCK_CLEAR);
		case (r.ci)
			cllc_pkg::CI_L1D: enabled = r.regs.d_en;
			cllc_pkg::CI_L1I: enabled = r.regs.i_en;
			default: enabled = r.regs.l2_en;
		endcase
		unable = !enabled || r.op.page_attribute_bits[cllc_pkg::ATTR_CI_BIT] ||
			(r.ci == cllc_pkg::CI_L2 && is_instr && r.regs.l2_data_only) ||
			(r.ci == cllc_pkg::CI_L2 && !is_instr && r.regs.l2_instr_only);
		exc = cllc_pkg::EXC_NONE;
		if (r.regs.user_mode_bit)
		begin
			if (!r.regs.user_lock_enable)
				exc = cllc_pkg::EXC_PRIVILEGED;
		end
		else if (r.regs.guest_state_bit && r.regs.lock_privilege_protect)
			exc = cllc_pkg::EXC_HYP_PRIVILEGE;
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		n = r;
		n.done = 1'b0;
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		n.prdata = 32'h0000_0000;
		wr_en = 1'b0;
		wr_way = hit_way;
		wr_lock = 1'b1;
		wr_mod = 1'b0;
		wr_fill = 1'b0;
		flash_lock = '0;
		flash_inv = '0;
		apb_wr = psel && penable && r.pready && pwrite;
		if (psel && !penable)
		begin
			n.pready = 1'b1;
			n.pslverr = !addr_ok(paddr);
			n.prdata = reg_read(r.regs, paddr);
		end
		if (apb_wr)
		begin
			case (paddr)
				cllc_pkg::ADDR_L1D_CS:
				begin
					n.regs.d_en = pwdata[cllc_pkg::BIT_EN];
					if (pwdata[cllc_pkg::BIT_UL])
						n.regs.data_unable_to_lock_flag = 1'b0;
					if (pwdata[cllc_pkg::BIT_LO])
						n.regs.data_overlock_flag = 1'b0;
					flash_inv[cllc_pkg::CI_L1D] = pwdata[cllc_pkg::BIT_FINV];
					flash_lock[cllc_pkg::CI_L1D] = pwdata[cllc_pkg::BIT_LFC];
				end
				cllc_pkg::ADDR_L1I_CS:
				begin
					n.regs.i_en = pwdata[cllc_pkg::BIT_EN];
					if (pwdata[cllc_pkg::BIT_UL])
						n.regs.instr_unable_to_lock_flag = 1'b0;
					if (pwdata[cllc_pkg::BIT_LO])
						n.regs.instr_overlock_flag = 1'b0;
					flash_inv[cllc_pkg::CI_L1I] = pwdata[cllc_pkg::BIT_FINV];
					flash_lock[cllc_pkg::CI_L1I] = pwdata[cllc_pkg::BIT_LFC];
				end
				cllc_pkg::ADDR_L2_CS:
				begin
					n.regs.l2_en = pwdata[cllc_pkg::BIT_EN];
					if (pwdata[cllc_pkg::BIT_LO])
						n.regs.l2_overlock_flag = 1'b0;
					n.regs.l2_overlock_allocate = pwdata[cllc_pkg::BIT_L2_OA];
					n.regs.l2_data_only = pwdata[cllc_pkg::BIT_L2_DO];
					n.regs.l2_instr_only = pwdata[cllc_pkg::BIT_L2_IO];
					flash_lock[cllc_pkg::CI_L2] = pwdata[cllc_pkg::BIT_LFC];
				end
				cllc_pkg::ADDR_PROTECT:
					n.regs.lock_privilege_protect = pwdata[cllc_pkg::BIT_PROTECT];
				cllc_pkg::ADDR_MSTATE:
				begin
					n.regs.user_mode_bit = pwdata[cllc_pkg::BIT_USER];
					n.regs.guest_state_bit = pwdata[cllc_pkg::BIT_GUEST];
					n.regs.user_lock_enable = pwdata[cllc_pkg::BIT_ULE];
				end
				default:
					n.regs = n.regs;
			endcase
		end
		// Flags are set after the bus write so that a set wins over a clear.
		case (r.st)
			cllc_pkg::ST_IDLE:
			begin
				if (op_valid)
				begin
					n.op = op;
					n.op.addr[cllc_pkg::LINE_OFS_W-1:0] = '0;
					n.ci = (op.target_cache_select == cllc_pkg::TGT_L2) ? cllc_pkg::CI_L2 :
						((op.kind == cllc_pkg::OP_INSTR_LOCK_CLEAR ||
						op.kind == cllc_pkg::OP_INSTR_TOUCH_LOCK) ?
						cllc_pkg::CI_L1I : cllc_pkg::CI_L1D);
					n.st = cllc_pkg::ST_EXEC;
				end
			end
			cllc_pkg::ST_EXEC:
			begin
				n.done = 1'b1;
				n.exc = exc;
				n.locked = 1'b0;
				n.modified = 1'b0;
				n.st = cllc_pkg::ST_IDLE;
				if (exc != cllc_pkg::EXC_NONE ||
					(r.op.target_cache_select != cllc_pkg::TGT_L1 &&
					r.op.target_cache_select != cllc_pkg::TGT_L2))
				begin
					n.locked = 1'b0;
				end
				else if (is_clear)
				begin
					if (enabled && hit)
					begin
						wr_en = 1'b1;
						wr_lock = 1'b0;
						wr_mod = mod_mem[r.ci][lk_set][hit_way];
					end
				end
				else if (unable)
				begin
					if (is_instr)
						n.regs.instr_unable_to_lock_flag = 1'b1;
					else
						n.regs.data_unable_to_lock_flag = 1'b1;
				end
				else if (hit)
				begin
					wr_en = 1'b1;
					wr_mod = mod_mem[r.ci][lk_set][hit_way] ||
						r.op.kind == cllc_pkg::OP_DATA_STORE_LOCK;
					n.locked = 1'b1;
					n.modified = wr_mod;
				end
				else if (all_locked)
				begin
					if (r.ci == cllc_pkg::CI_L2)
					begin
						n.regs.l2_overlock_flag = 1'b1;
						if (r.regs.l2_overlock_allocate)
						begin
							n.victim = r.rr;
							n.fill_req = 1'b1;
							n.done = 1'b0;
							n.st = cllc_pkg::ST_FILL;
						end
					end
					else if (is_instr)
						n.regs.instr_overlock_flag = 1'b1;
					else
						n.regs.data_overlock_flag = 1'b1;
				end
				else
				begin
					n.victim = 4'(free_way);
					n.fill_req = 1'b1;
					n.done = 1'b0;
					n.st = cllc_pkg::ST_FILL;
				end
			end
			cllc_pkg::ST_FILL:
			begin
				if (fill_ack)
				begin
					n.fill_req = 1'b0;
					n.done = 1'b1;
					n.st = cllc_pkg::ST_IDLE;
					if (fill_err)
					begin
						if (is_instr)
							n.regs.instr_unable_to_lock_flag = 1'b1;
						else
							n.regs.data_unable_to_lock_flag = 1'b1;
					end
					else
					begin
						wr_en = 1'b1;
						wr_fill = 1'b1;
						wr_way = r.victim[WAY_W-1:0];
						wr_mod = r.op.kind == cllc_pkg::OP_DATA_STORE_LOCK;
						n.rr = r.rr + 4'h1;
						n.locked = 1'b1;
						n.modified = wr_mod;
					end
				end
			end
			default:
				n.st = cllc_pkg::ST_IDLE;
		endcase
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r <= '0;
			r.st <= cllc_pkg::ST_IDLE;
			r.rr <= cllc_pkg::RST_RR;
			r.regs.d_en <= cllc_pkg::RST_EN;
			r.regs.i_en <= cllc_pkg::RST_EN;
			r.regs.l2_en <= cllc_pkg::RST_EN;
			r.regs.data_unable_to_lock_flag <= cllc_pkg::RST_FLAG;
			r.exc <= cllc_pkg::EXC_NONE;
		end
		else
			r <= n;
	end

	// ****************************************
	// Line arrays
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int c = 0; c < cllc_pkg::NCACHE; c++)
				for (int s = 0; s < SETS; s++)
					for (int w = 0; w < WAYS; w++)
					begin
						valid_mem[c][s][w] <= 1'b0;
						lock_mem[c][s][w] <= 1'b0;
						mod_mem[c][s][w] <= 1'b0;
						tag_mem[c][s][w] <= '0;
					end
		end
		else
		begin
			if (wr_en)
			begin
				valid_mem[r.ci][lk_set][wr_way] <= 1'b1;
				lock_mem[r.ci][lk_set][wr_way] <= wr_lock;
				mod_mem[r.ci][lk_set][wr_way] <= wr_mod;
				if (wr_fill)
					tag_mem[r.ci][lk_set][wr_way] <= lk_tag;
			end
			for (int c = 0; c < cllc_pkg::NCACHE; c++)
				for (int s = 0; s < SETS; s++)
					for (int w = 0; w < WAYS; w++)
					begin
						if (flash_lock[c] || flash_inv[c])
							lock_mem[c][s][w] <= 1'b0;
						if (flash_inv[c])
							valid_mem[c][s][w] <= 1'b0;
					end
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign op_ready = r.st[0];
	assign op_done = r.done;
	assign op_exc = r.exc;
	assign op_locked = r.locked;
	assign op_modified = r.modified;
	assign fill_req = r.fill_req;
	assign fill_addr = r.op.addr;
	assign fill_target = r.ci;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic any_l1d_lock;
	always_comb
	begin
		any_l1d_lock = 1'b0;
		for (int s = 0; s < SETS; s++)
			for (int w = 0; w < WAYS; w++)
				any_l1d_lock = any_l1d_lock | lock_mem[cllc_pkg::CI_L1D][s][w];
	end

	sequence exec_tgt_s;
		r.st == cllc_pkg::ST_EXEC && (r.op.target_cache_select == cllc_pkg::TGT_L1 ||
			r.op.target_cache_select == cllc_pkg::TGT_L2);
	endsequence
	sequence set_miss_s;
		exec_tgt_s ##0 (exc == cllc_pkg::EXC_NONE && !is_clear && !unable && !hit && !all_locked);
	endsequence

	hyp_priv_a: assert property (exec_tgt_s ##0 (!r.regs.user_mode_bit &&
		r.regs.guest_state_bit && r.regs.lock_privilege_protect) |=>
		op_done && op_exc == cllc_pkg::EXC_HYP_PRIVILEGE && !op_locked)
		else $error("guest lock op did not raise hypervisor privilege");
	user_priv_a: assert property (exec_tgt_s ##0 (r.regs.user_mode_bit &&
		r.regs.user_lock_enable) |=> op_exc == cllc_pkg::EXC_NONE)
		else $error("permitted user lock op raised an exception");
	unable_flag_a: assert property (exec_tgt_s ##0 (exc == cllc_pkg::EXC_NONE && !is_clear &&
		unable && !is_instr) |=> r.regs.data_unable_to_lock_flag && !op_locked && !fill_req)
		else $error("unable to lock not flagged");
	fill_lock_a: assert property (set_miss_s |=> fill_req ##1 (fill_req || op_done))
		else $error("missing line not fetched");
	fill_err_a: assert property (fill_req && fill_ack && fill_err |=>
		op_done && !op_locked && (r.regs.data_unable_to_lock_flag ||
		r.regs.instr_unable_to_lock_flag))
		else $error("fill error not reported as unable to lock");
	l1_over_a: assert property (exec_tgt_s ##0 (exc == cllc_pkg::EXC_NONE && !is_clear &&
		!unable && !hit && all_locked && r.ci == cllc_pkg::CI_L1D) |=>
		r.regs.data_overlock_flag && !fill_req && $stable(r.regs.data_unable_to_lock_flag))
		else $error("L1 overlock mishandled");
	l2_over_a: assert property (exec_tgt_s ##0 (exc == cllc_pkg::EXC_NONE && !is_clear &&
		!unable && !hit && all_locked && r.ci == cllc_pkg::CI_L2) |=>
		r.regs.l2_overlock_flag && fill_req == $past(r.regs.l2_overlock_allocate))
		else $error("L2 overlock mishandled");
	flash_clr_a: assert property (apb_wr && paddr == cllc_pkg::ADDR_L1D_CS &&
		pwdata[cllc_pkg::BIT_LFC] && r.st != cllc_pkg::ST_EXEC && r.st != cllc_pkg::ST_FILL
		|=> !any_l1d_lock)
		else $error("data lock flash clear left a lock");
	clear_off_a: assert property (exec_tgt_s ##0 (is_clear && !enabled) |-> !wr_en)
		else $error("lock clear acted on a disabled cache");
	sticky_a: assert property (r.regs.data_overlock_flag && !(apb_wr &&
		paddr == cllc_pkg::ADDR_L1D_CS && pwdata[cllc_pkg::BIT_LO]) |=> r.regs.data_overlock_flag)
		else $error("overlock flag dropped without a clear");

endmodule

/* sim/cllc_fill_model.sv */
// Line fill source model answering the block's fill requests.
`timescale 1ns/1ps
module cllc_fill_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Fill port
	input wire logic fill_req,
	output logic fill_ack,
	output logic fill_err,
	// Behaviour controls
	input wire logic [3:0] delay,
	input wire logic err_mode
);
	logic [3:0] cnt;
	logic flip;
	// Error line toggles while no answer is given.
	assign fill_err = fill_ack ? err_mode : flip;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt <= 4'h0;
			fill_ack <= 1'b0;
			flip <= 1'b0;
		end
		else
		begin
			flip <= ~flip;
			if (fill_req && !fill_ack && cnt >= delay)
			begin
				fill_ack <= 1'b1;
				cnt <= 4'h0;
			end
			else
			begin
				fill_ack <= 1'b0;
				cnt <= (fill_req && !fill_ack) ? cnt + 4'h1 : 4'h0;
			end
		end
	end
endmodule

/* sim/cllc_top_tb_top.sv */
// Self-checking testbench of the cache line lock control block.
`timescale 1ns/1ps
module cllc_top_tb_top;
	// ****************************************
	// Signals, clock, design and fill source
	// ****************************************
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic op_valid = 1'b0;
	cllc_pkg::cllc_op_t op = '0;
	logic op_ready;
	logic op_done;
	cllc_pkg::cllc_exc_t op_exc;
	logic op_locked;
	logic op_modified;
	logic fill_req;
	logic [31:0] fill_addr;
	logic [1:0] fill_target;
	logic fill_ack;
	logic fill_err;
	logic [3:0] delay = 4'h0;
	logic err_mode = 1'b0;
	int n_errors = 0;
	int total_checks = 0;
	always #10 pclk = ~pclk;
	cllc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .op_valid(op_valid), .op(op), .op_ready(op_ready),
		.op_done(op_done), .op_exc(op_exc), .op_locked(op_locked), .op_modified(op_modified),
		.fill_req(fill_req), .fill_addr(fill_addr), .fill_target(fill_target),
		.fill_ack(fill_ack), .fill_err(fill_err));
	cllc_fill_model i_fill (.pclk(pclk), .presetn(presetn), .fill_req(fill_req),
		.fill_ack(fill_ack), .fill_err(fill_err), .delay(delay), .err_mode(err_mode));
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, exp);
		chk({31'h0, e}, {31'h0, a > cllc_pkg::ADDR_MSTATE});
	endtask
	task automatic lk(input cllc_pkg::cllc_kind_t k, input logic [1:0] t, input logic [31:0] a,
		input logic [4:0] pa, input logic [1:0] ex, input logic [1:0] lm);
		int i;
		@(posedge pclk);
		op_valid <= 1'b1;
		op <= {k, t, a, pa};
		@(posedge pclk);
		op_valid <= 1'b0;
		@(posedge pclk);
		chk({31'h0, op_ready}, 32'h0);
		for (i = 0; i < 200 && op_done !== 1'b1; i++)
		begin
			@(posedge pclk);
		end
		chk({28'h0, op_ready, op_done, op_exc}, {28'h0, 2'h3, ex});
		if (ex == 2'h0)
			chk({30'h0, op_locked, op_modified}, {30'h0, lm});
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		int i;
		for (i = 0; i < 6; i++)
			rchk(8'(4 * i), 32'h0); // The sixth word is unmapped and answers with an error.
	endtask
	task automatic t_unable;
		lk(cllc_pkg::OP_DATA_TOUCH_LOCK, 2'h0, 32'h100, 5'h00, 2'h0, 2'h0);
		rchk(8'h00, 32'h08);
		lk(cllc_pkg::OP_DATA_LOCK_CLEAR, 2'h0, 32'h100, 5'h00, 2'h0, 2'h0);
		wr(8'h00, 32'h09);
		rchk(8'h00, 32'h01);
		lk(cllc_pkg::OP_DATA_TOUCH_LOCK, 2'h0, 32'h100, 5'h08, 2'h0, 2'h0);
		rchk(8'h00, 32'h09);
		wr(8'h00, 32'h09);
		lk(cllc_pkg::OP_DATA_TOUCH_LOCK, 2'h0, 32'h140, 5'h00, 2'h0, 2'h2);
		rchk(8'h00, 32'h01);
		err_mode <= 1'b1;
		lk(cllc_pkg::OP_DATA_TOUCH_LOCK, 2'h0, 32'h180, 5'h00, 2'h0, 2'h0);
		err_mode <= 1'b0;
		rchk(8'h00, 32'h09);
		wr(8'h00, 32'h09);
		lk(cllc_pkg::OP_DATA_STORE_LOCK, 2'h0, 32'h1c0, 5'h00, 2'h0, 2'h3);
	endtask
	task automatic t_over;
		int i;
		delay <= 4'h7;
		for (i = 0; i < 4; i++)
			lk(cllc_pkg::OP_DATA_TOUCH_LOCK, 2'h0, 32'h2000 + i * 32'h400, 5'h0, 2'h0, 2'h2);
		lk(cllc_pkg::OP_DATA_TOUCH_LOCK, 2'h0, 32'h3000, 5'h0, 2'h0, 2'h0);
		rchk(8'h00, 32'h11);
		lk(cllc_pkg::OP_DATA_LOCK_CLEAR, 2'h0, 32'h2400, 5'h0, 2'h0, 2'h0);
		lk(cllc_pkg::OP_DATA_TOUCH_LOCK, 2'h0, 32'h3000, 5'h0, 2'h0, 2'h2);
		wr(8'h00, 32'h15);
		lk(cllc_pkg::OP_DATA_TOUCH_LOCK, 2'h0, 32'h3400, 5'h0, 2'h0, 2'h2);
		for (i = 0; i < 3; i++)
			lk(cllc_pkg::OP_DATA_TOUCH_LOCK, 2'h0, 32'h2800 + i * 32'h400, 5'h0, 2'h0, 2'h2);
		wr(8'h00, 32'h03);
		lk(cllc_pkg::OP_DATA_TOUCH_LOCK, 2'h0, 32'h3800, 5'h0, 2'h0, 2'h2);
		delay <= 4'h0;
	endtask
	task automatic t_l2;
		int i;
		wr(8'h08, 32'h41);
		lk(cllc_pkg::OP_INSTR_TOUCH_LOCK, 2'h2, 32'h5000, 5'h0, 2'h0, 2'h0);
		rchk(8'h04, 32'h08);
		wr(8'h08, 32'h81);
		lk(cllc_pkg::OP_DATA_TOUCH_LOCK, 2'h2, 32'h5000, 5'h0, 2'h0, 2'h0);
		rchk(8'h00, 32'h09);
		wr(8'h08, 32'h01);
		for (i = 0; i < 4; i++)
			lk(cllc_pkg::OP_DATA_TOUCH_LOCK, 2'h2, 32'h6000 + i * 32'h400, 5'h0, 2'h0, 2'h2);
		lk(cllc_pkg::OP_DATA_TOUCH_LOCK, 2'h2, 32'h7000, 5'h0, 2'h0, 2'h0);
		rchk(8'h08, 32'h11);
		wr(8'h08, 32'h31);
		lk(cllc_pkg::OP_DATA_TOUCH_LOCK, 2'h2, 32'h7000, 5'h0, 2'h0, 2'h2);
		rchk(8'h08, 32'h31);
		wr(8'h08, 32'h15);
		lk(cllc_pkg::OP_DATA_TOUCH_LOCK, 2'h2, 32'h7400, 5'h0, 2'h0, 2'h2);
		chk({30'h0, fill_target}, {30'h0, cllc_pkg::CI_L2});
	endtask
	task automatic t_priv;
		logic [5:0] tbl [5] = '{6'h2a, 6'h25, 6'h34, 6'h08, 6'h20};
		int i;
		logic [1:0] lm;
		for (i = 0; i < 5; i++)
		begin
			wr(8'h0c, {31'h0, tbl[i][5]});
			wr(8'h10, {29'h0, tbl[i][4:2]});
			lm = (i == 2) ? 2'h3 : 2'h0;
			lk(cllc_pkg::cllc_kind_t'(i), 2'h0, 32'h40, 5'h0, tbl[i][1:0], lm);
		end
	endtask
	task automatic t_instr;
		wr(8'h04, 32'h19);
		lk(cllc_pkg::OP_INSTR_TOUCH_LOCK, 2'h0, 32'h8024, 5'h0, 2'h0, 2'h2);
		chk(fill_addr, 32'h8000);
		chk({30'h0, fill_target}, {30'h0, cllc_pkg::CI_L1I});
		lk(cllc_pkg::OP_INSTR_LOCK_CLEAR, 2'h0, 32'h8000, 5'h0, 2'h0, 2'h0);
		rchk(8'h04, 32'h01);
	endtask
	task automatic close_out;
		$display("Checks %0d, errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_unable;
		t_over;
		t_l2;
		t_priv;
		t_instr;
		close_out;
	end
	initial
	begin
		#400000;
		n_errors++;
		close_out;
	end
endmodule
